// file: host_bridge_model.sv
`timescale 1ns/1ps
module host_bridge_model (
  input wire logic sys_clk, // pci clock
  input wire logic devsel_n, // target select
  input wire logic devsel_oe, // target drives devsel
  input wire logic trdy_n, // target ready
  input wire logic [31:0] ad_out, // read data
  output logic frame_n, // frame
  output logic irdy_n, // initiator ready
  output logic [3:0] cbe_n, // command / byte enables
  output logic [31:0] ad_in, // address / data
  output logic scsi_config_select, // scsi select
  output logic enet_config_select // ethernet select
);
  // ----------------------------------------
  // host side of single phase cycles
  // ----------------------------------------
  // idle bus levels at time zero
  initial begin
    frame_n = 1'b1;
    irdy_n = 1'b1;
    cbe_n = 4'hF;
    ad_in = 32'h0000_0000;
    scsi_config_select = 1'b0;
    enet_config_select = 1'b0;
  end
  // one cycle; claimed reports whether devsel was seen
  task automatic bus_cycle(input logic [3:0] cmd, input logic [31:0] addr,
      input logic [31:0] wd, input logic [3:0] be_n, input logic [1:0] sel,
      output logic claimed, output logic [31:0] rdata);
    int n;
    claimed = 1'b0;
    rdata = 32'h0000_0000;
    @(negedge sys_clk);
    frame_n = 1'b0;
    cbe_n = cmd;
    ad_in = addr;
    scsi_config_select = sel[0];
    enet_config_select = sel[1];
    @(negedge sys_clk);
    // single data phase, frame drops with irdy
    frame_n = 1'b1;
    irdy_n = 1'b0;
    cbe_n = be_n;
    ad_in = wd;
    scsi_config_select = ~sel[0]; // select only counts in address phase
    enet_config_select = ~sel[1];
    n = 0;
    while (n < 12) begin
      // target outputs are settled by the falling edge
      @(negedge sys_clk);
      if (devsel_oe === 1'b1 && devsel_n === 1'b0) claimed = 1'b1;
      if (claimed && trdy_n === 1'b0) break;
      n++;
    end
    rdata = ad_out;
    @(negedge sys_clk);
    irdy_n = 1'b1;
    ad_in = ~ad_in; // released lines keep no value
    cbe_n = ~cbe_n;
    repeat (4) @(negedge sys_clk);
  endtask : bus_cycle
endmodule : host_bridge_model

// file: io_decode_if.sv
`timescale 1ns/1ps
interface io_decode_if;
  logic [31:0] addr;
  logic [3:0] cmd;
  logic [31:0] scsi_base;
  logic [31:0] enet_base;
  logic scsi_en;
  logic enet_en;
  logic master_busy;
  logic hit;
  pci_target_pkg::io_block_e block;
  logic [6:0] offset;
  modport decoder (
    input addr, cmd, scsi_base, enet_base, scsi_en, enet_en, master_busy,
    output hit, block, offset
  );
  modport owner (
    output addr, cmd, scsi_base, enet_base, scsi_en, enet_en, master_busy,
    input hit, block, offset
  );
endinterface : io_decode_if

// file: io_window_decode.sv
`timescale 1ns/1ps
module io_window_decode (
  io_decode_if.decoder dec // address and base values in, hit out
);
  logic is_io;
  logic scsi_match;
  logic enet_match;
  logic [6:0] scsi_ofs;

  // ---------------------------------------------------------------
  // window match
  // ---------------------------------------------------------------
  always_comb begin
    is_io = (dec.cmd == pci_target_pkg::CMD_IO_READ) ||
            (dec.cmd == pci_target_pkg::CMD_IO_WRITE);
    scsi_ofs = dec.addr[6:0];
    scsi_match = (dec.addr[31:pci_target_pkg::SCSI_ALIGN_BITS] ==
                  dec.scsi_base[31:pci_target_pkg::SCSI_ALIGN_BITS]) &&
                 (scsi_ofs <= pci_target_pkg::SCSI_DMA_LAST);
    enet_match = dec.addr[31:pci_target_pkg::ENET_ALIGN_BITS] ==
                 dec.enet_base[31:pci_target_pkg::ENET_ALIGN_BITS];
  end

  // ---------------------------------------------------------------
  // block select
  // ---------------------------------------------------------------
  always_comb begin
    dec.hit = 1'b0;
    dec.block = pci_target_pkg::BLK_SCSI_CORE;
    dec.offset = scsi_ofs;
    if (is_io && !dec.master_busy) begin
      if (dec.scsi_en && scsi_match) begin
        dec.hit = 1'b1;
        if (scsi_ofs <= pci_target_pkg::SCSI_CORE_LAST) begin
          dec.block = pci_target_pkg::BLK_SCSI_CORE;
        end else begin
          dec.block = pci_target_pkg::BLK_SCSI_DMA;
          dec.offset = scsi_ofs - pci_target_pkg::SCSI_DMA_FIRST;
        end
      end else if (dec.enet_en && enet_match) begin
        dec.hit = 1'b1;
        dec.block = pci_target_pkg::BLK_ENET;
        dec.offset = {2'b00, dec.addr[4:0]};
      end
    end
  end
endmodule : io_window_decode

// file: pci_target_config_decode.sv
`timescale 1ns/1ps
module pci_target_config_decode #(
  parameter logic [31:0] SCSI_ID = 32'h1234_5678, // arbitrary value
  parameter logic [31:0] ENET_ID = 32'h1234_5679, // arbitrary value
  parameter logic [31:0] SCSI_CLASS = 32'h0100_0000, // arbitrary value
  parameter logic [31:0] ENET_CLASS = 32'h0200_0000 // arbitrary value
) (
  input wire logic sys_clk, // pci clock
  input wire logic sys_rst, // async reset, high
  input wire logic frame_n, // bus frame
  input wire logic irdy_n, // initiator ready
  input wire logic [3:0] cbe_n, // command / byte enables
  input wire logic [31:0] ad_in, // address/data in
  output logic [31:0] ad_out, // read data out
  output logic ad_oe, // drive ad
  output logic devsel_n, // device select value
  output logic devsel_oe, // drive devsel
  output logic trdy_n, // target ready value
  output logic trdy_oe, // drive trdy
  input wire logic scsi_config_select, // scsi config select
  input wire logic enet_config_select, // ethernet config select
  input wire logic scsi_bus_grant_n, // scsi grant
  input wire logic enet_bus_grant_n, // ethernet grant
  output logic scsi_bus_request_n, // scsi request
  output logic enet_bus_request_n, // ethernet request
  output logic scsi_interrupt_out_n, // scsi interrupt
  output logic enet_interrupt_out_n, // ethernet interrupt
  input wire logic scsi_dma_need, // scsi engine wants bus
  input wire logic enet_dma_need, // ethernet engine wants bus
  input wire logic scsi_irq, // scsi interrupt source
  input wire logic enet_irq, // ethernet interrupt source
  output logic io_strobe, // one cycle register access
  output logic io_write, // access is a write
  output pci_target_pkg::io_block_e io_block, // target block
  output logic [6:0] io_offset, // byte offset in block
  output logic [31:0] io_wdata, // write data
  output logic [3:0] io_be, // byte enables, high
  input wire logic [31:0] io_rdata // read data, cycle after strobe
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CLAIM = 3'b001,
    ST_WAIT = 3'b010,
    ST_DATA = 3'b011,
    ST_TURN = 3'b100
  } tgt_state_e;

  localparam int SYNC_W = 43;

  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic frame_s;
  logic frame_prev;
  logic irdy_s;
  logic [3:0] cbe_s;
  logic [31:0] ad_s;
  logic sel_a_s;
  logic sel_b_s;
  logic gnt_a_s;
  logic gnt_b_s;
  logic frame_start;
  logic cfg_cmd;

  tgt_state_e st, next_st;
  logic cur_cfg, next_cur_cfg;
  logic cur_fn, next_cur_fn;
  logic cur_wr, next_cur_wr;
  logic [7:0] cur_reg, next_cur_reg;
  logic next_devsel_n, next_devsel_oe, next_trdy_n, next_trdy_oe;
  logic [31:0] next_ad_out;
  logic next_ad_oe;
  logic next_io_strobe, next_io_write;
  pci_target_pkg::io_block_e next_io_block;
  logic [6:0] next_io_offset;
  logic [31:0] next_io_wdata;
  logic [3:0] next_io_be;
  logic [15:0] cmd [2];
  logic [15:0] next_cmd [2];
  logic [31:0] bar [2];
  logic [31:0] next_bar [2];
  logic [31:0] mail [2];
  logic [31:0] next_mail [2];
  logic [31:0] cfg_rdata;
  logic [31:0] bar_mask;
  logic [31:0] cmd_merged;
  logic next_req_a, next_req_b;

  io_decode_if dec_if ();

  // merge enabled write bytes into an old value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
      input logic [31:0] wr, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // sampled on rising edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= {2'b11, 4'hF, 32'h0000_0000, 2'b00, 2'b11, 1'b1};
      sync2 <= {2'b11, 4'hF, 32'h0000_0000, 2'b00, 2'b11, 1'b1};
      frame_prev <= 1'b1;
    end else begin
      sync1 <= {frame_n, irdy_n, cbe_n, ad_in, scsi_config_select,
                enet_config_select, scsi_bus_grant_n, enet_bus_grant_n,
                1'b1};
      sync2 <= sync1;
      frame_prev <= frame_s;
    end
  end

  // unpack synchronised pins
  assign {frame_s, irdy_s, cbe_s, ad_s, sel_a_s, sel_b_s, gnt_a_s,
          gnt_b_s} = sync2[SYNC_W-1:1];
  assign frame_start = frame_prev && !frame_s;
  assign cfg_cmd = (cbe_s == pci_target_pkg::CMD_CFG_READ) ||
                   (cbe_s == pci_target_pkg::CMD_CFG_WRITE);
  // command write merged with enabled bytes
  assign cmd_merged = merge_bytes({16'h0000, cmd[cur_fn]}, ad_s, ~cbe_s);

  // ---------------------------------------------------------------
  // i/o window decode
  // ---------------------------------------------------------------
  // bases steer decode
  assign dec_if.addr = ad_s;
  assign dec_if.cmd = cbe_s;
  assign dec_if.scsi_base = bar[0];
  assign dec_if.enet_base = bar[1];
  assign dec_if.scsi_en = cmd[0][pci_target_pkg::IO_EN_BIT];
  assign dec_if.enet_en = cmd[1][pci_target_pkg::IO_EN_BIT];
  assign dec_if.master_busy = (!scsi_bus_request_n && !gnt_a_s) ||
                              (!enet_bus_request_n && !gnt_b_s);

  io_window_decode u_dec (
    .dec(dec_if.decoder)
  );

  // ---------------------------------------------------------------
  // configuration read mux
  // ---------------------------------------------------------------
  // identification, command, class, base and mailbox registers
  always_comb begin
    case (cur_reg)
      pci_target_pkg::CFG_ID_OFS: cfg_rdata = cur_fn ? ENET_ID : SCSI_ID;
      pci_target_pkg::CFG_CMD_OFS: cfg_rdata = {16'h0000, cmd[cur_fn]};
      pci_target_pkg::CFG_CLASS_OFS: begin
        cfg_rdata = cur_fn ? ENET_CLASS : SCSI_CLASS;
      end
      pci_target_pkg::CFG_BAR_OFS: cfg_rdata = bar[cur_fn];
      pci_target_pkg::CFG_MAIL_OFS: cfg_rdata = mail[cur_fn];
      default: cfg_rdata = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // target state machine
  // ---------------------------------------------------------------
  // target machine
  always_comb begin
    next_st = st;
    next_cur_cfg = cur_cfg;
    next_cur_fn = cur_fn;
    next_cur_wr = cur_wr;
    next_cur_reg = cur_reg;
    next_devsel_n = devsel_n;
    next_devsel_oe = devsel_oe;
    next_trdy_n = trdy_n;
    next_trdy_oe = trdy_oe;
    next_ad_out = ad_out;
    next_ad_oe = ad_oe;
    next_io_strobe = 1'b0;
    next_io_write = io_write;
    next_io_block = io_block;
    next_io_offset = io_offset;
    next_io_wdata = io_wdata;
    next_io_be = io_be;
    next_cmd = cmd;
    next_bar = bar;
    next_mail = mail;
    bar_mask = cur_fn ? {{(32 - pci_target_pkg::ENET_ALIGN_BITS){1'b1}},
                         {pci_target_pkg::ENET_ALIGN_BITS{1'b0}}}
                      : {{(32 - pci_target_pkg::SCSI_ALIGN_BITS){1'b1}},
                         {pci_target_pkg::SCSI_ALIGN_BITS{1'b0}}};
    case (st)
      ST_IDLE: begin
        if (frame_start) begin
          if (cfg_cmd && (sel_a_s || sel_b_s)) begin
            next_st = ST_CLAIM;
            next_cur_cfg = 1'b1;
            next_cur_fn = !sel_a_s;
            next_cur_wr = cbe_s[0];
            next_cur_reg = {ad_s[7:2], 2'b00};
          end else if (dec_if.hit) begin
            next_st = ST_CLAIM;
            next_cur_cfg = 1'b0;
            next_cur_wr = cbe_s[0];
            next_io_block = dec_if.block;
            next_io_offset = {dec_if.offset[6:2], 2'b00};
            next_io_write = cbe_s[0];
            next_io_strobe = !cbe_s[0];
            next_io_be = 4'hF;
          end
          if ((cfg_cmd && (sel_a_s || sel_b_s)) || dec_if.hit) begin
            next_devsel_n = 1'b0;
            next_devsel_oe = 1'b1;
            next_trdy_n = 1'b1;
            next_trdy_oe = 1'b1;
          end
        end
      end
      ST_CLAIM: begin
        next_st = ST_WAIT;
        next_ad_oe = !cur_wr;
      end
      ST_WAIT: begin
        next_ad_out = cur_cfg ? cfg_rdata : io_rdata;
        next_trdy_n = 1'b0;
        next_st = ST_DATA;
      end
      ST_DATA: begin
        if (!irdy_s) begin
          next_trdy_n = 1'b1;
          next_devsel_n = 1'b1;
          next_ad_oe = 1'b0;
          next_st = ST_TURN;
          if (cur_wr && cur_cfg) begin
            case (cur_reg)
              pci_target_pkg::CFG_CMD_OFS: begin
                next_cmd[cur_fn] = (cmd[cur_fn] &
                    ~pci_target_pkg::CMD_WR_MASK) |
                    (cmd_merged[15:0] & pci_target_pkg::CMD_WR_MASK);
              end
              pci_target_pkg::CFG_BAR_OFS: begin
                next_bar[cur_fn] = (merge_bytes(bar[cur_fn], ad_s,
                    ~cbe_s) & bar_mask) | pci_target_pkg::BAR_IO_FLAG;
              end
              pci_target_pkg::CFG_MAIL_OFS: begin
                next_mail[cur_fn] = merge_bytes(mail[cur_fn], ad_s,
                                                ~cbe_s);
              end
              default: begin
              end
            endcase
          end else if (cur_wr) begin
            next_io_strobe = 1'b1;
            next_io_wdata = ad_s;
            next_io_be = ~cbe_s;
          end
        end
      end
      ST_TURN: begin
        next_devsel_oe = 1'b0;
        next_trdy_oe = 1'b0;
        next_st = ST_IDLE;
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    next_req_a = scsi_dma_need && cmd[0][pci_target_pkg::MASTER_EN_BIT];
    next_req_b = enet_dma_need && cmd[1][pci_target_pkg::MASTER_EN_BIT];
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  // outputs on rising edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= ST_IDLE;
      cur_cfg <= 1'b0;
      cur_fn <= 1'b0;
      cur_wr <= 1'b0;
      cur_reg <= 8'h00;
      devsel_n <= 1'b1;
      devsel_oe <= 1'b0;
      trdy_n <= 1'b1;
      trdy_oe <= 1'b0;
      ad_out <= 32'h0000_0000;
      ad_oe <= 1'b0;
      io_strobe <= 1'b0;
      io_write <= 1'b0;
      io_block <= pci_target_pkg::BLK_SCSI_CORE;
      io_offset <= 7'h00;
      io_wdata <= 32'h0000_0000;
      io_be <= 4'h0;
      cmd <= '{pci_target_pkg::CMD_RESET, pci_target_pkg::CMD_RESET};
      bar <= '{pci_target_pkg::BAR_RESET, pci_target_pkg::BAR_RESET};
      mail <= '{pci_target_pkg::MAIL_RESET, pci_target_pkg::MAIL_RESET};
      scsi_bus_request_n <= 1'b1;
      enet_bus_request_n <= 1'b1;
      scsi_interrupt_out_n <= 1'b1;
      enet_interrupt_out_n <= 1'b1;
    end else begin
      st <= next_st;
      cur_cfg <= next_cur_cfg;
      cur_fn <= next_cur_fn;
      cur_wr <= next_cur_wr;
      cur_reg <= next_cur_reg;
      devsel_n <= next_devsel_n;
      devsel_oe <= next_devsel_oe;
      trdy_n <= next_trdy_n;
      trdy_oe <= next_trdy_oe;
      ad_out <= next_ad_out;
      ad_oe <= next_ad_oe;
      io_strobe <= next_io_strobe;
      io_write <= next_io_write;
      io_block <= next_io_block;
      io_offset <= next_io_offset;
      io_wdata <= next_io_wdata;
      io_be <= next_io_be;
      cmd <= next_cmd;
      bar <= next_bar;
      mail <= next_mail;
      scsi_bus_request_n <= !next_req_a;
      enet_bus_request_n <= !next_req_b;
      scsi_interrupt_out_n <= !scsi_irq;
      enet_interrupt_out_n <= !enet_irq;
    end
  end
endmodule : pci_target_config_decode

// file: pci_target_config_decode_sva.sv
`timescale 1ns/1ps
module pci_target_config_decode_sva (
  input wire logic sys_clk, // pci clock
  input wire logic sys_rst, // async reset, high
  input wire logic frame_n, // bus frame
  input wire logic [3:0] cbe_n, // command / byte enables
  input wire logic scsi_config_select, // scsi select
  input wire logic enet_config_select, // ethernet select
  input wire logic devsel_oe, // drive devsel
  input wire logic trdy_n, // target ready value
  input wire logic trdy_oe, // drive trdy
  input wire logic ad_oe, // drive ad
  input wire logic io_strobe, // register access pulse
  input wire logic scsi_irq, // scsi interrupt source
  input wire logic enet_irq, // ethernet interrupt source
  input wire logic scsi_interrupt_out_n, // scsi interrupt
  input wire logic enet_interrupt_out_n // ethernet interrupt
);
  // ----------------------------------------
  // bus target timing checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // claim seen three samples after frame first sampled low
  property p_devsel_two;
    $rose(devsel_oe) |-> $past(frame_n, 3) == 1'b0 && $past(frame_n, 4);
  endproperty
  a_devsel_two: assert property (p_devsel_two)
    else $error("devsel not two clocks after frame");
  property p_trdy_third;
    $rose(devsel_oe) |-> trdy_n [*2] ##1 !trdy_n;
  endproperty
  a_trdy_third: assert property (p_trdy_third)
    else $error("trdy not on third data clock");
  property p_cfg_sel;
    $rose(devsel_oe) && $past(cbe_n, 3) inside {4'hA, 4'hB}
      |-> $past(scsi_config_select || enet_config_select, 3);
  endproperty
  a_cfg_sel: assert property (p_cfg_sel)
    else $error("config cycle claimed without select");
  property p_io_cmd;
    $rose(devsel_oe) |-> $past(cbe_n, 3) inside {4'h2, 4'h3, 4'hA, 4'hB};
  endproperty
  a_io_cmd: assert property (p_io_cmd)
    else $error("cycle claimed with foreign command");
  property p_pair;
    devsel_oe == trdy_oe;
  endproperty
  a_pair: assert property (p_pair)
    else $error("devsel and trdy drive differ");
  property p_ad_oe;
    ad_oe |-> devsel_oe;
  endproperty
  a_ad_oe: assert property (p_ad_oe)
    else $error("ad driven without claim");
  property p_strobe;
    io_strobe |=> !io_strobe;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("register strobe longer than one cycle");
  property p_int_scsi;
    !$past(sys_rst) |-> scsi_interrupt_out_n == !$past(scsi_irq);
  endproperty
  a_int_scsi: assert property (p_int_scsi)
    else $error("scsi interrupt pin wrong");
  property p_int_enet;
    !$past(sys_rst) |-> enet_interrupt_out_n == !$past(enet_irq);
  endproperty
  a_int_enet: assert property (p_int_enet)
    else $error("ethernet interrupt pin wrong");
  // main scenarios reached
  c_cfg_write: cover property ($rose(devsel_oe) && $past(cbe_n, 3) == 4'hB);
  c_read_data: cover property ($rose(ad_oe));
  c_strobe: cover property (io_strobe);
endmodule : pci_target_config_decode_sva

// file: pci_target_config_decode_tb.sv
`timescale 1ns/1ps
module pci_target_config_decode_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic frame_n, irdy_n, scsi_config_select, enet_config_select;
  logic [3:0] cbe_n, io_be, seen_be;
  logic [31:0] ad_in, ad_out, io_wdata, io_rdata, rdata, seen_wdata;
  logic ad_oe, devsel_n, devsel_oe, trdy_n, trdy_oe, claimed, seen_wr;
  logic scsi_bus_grant_n = 1'b1;
  logic enet_bus_grant_n = 1'b1;
  logic scsi_bus_request_n, enet_bus_request_n, io_strobe, io_write;
  logic scsi_interrupt_out_n, enet_interrupt_out_n;
  logic scsi_dma_need = 1'b0;
  logic enet_dma_need = 1'b0;
  logic scsi_irq = 1'b0;
  logic enet_irq = 1'b0;
  pci_target_pkg::io_block_e io_block, seen_blk;
  logic [6:0] io_offset, seen_ofs;
  int errors = 0;
  int comparisons = 0;
  // ----------------------------------------
  // clock, design, host and register blocks
  // ----------------------------------------
  always #2 sys_clk = ~sys_clk;
  pci_target_config_decode pci_target_config_decode_inst (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .frame_n(frame_n), .irdy_n(irdy_n), .cbe_n(cbe_n),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .devsel_n(devsel_n),
    .devsel_oe(devsel_oe), .trdy_n(trdy_n), .trdy_oe(trdy_oe),
    .scsi_config_select(scsi_config_select),
    .enet_config_select(enet_config_select),
    .scsi_bus_grant_n(scsi_bus_grant_n), .enet_bus_grant_n(enet_bus_grant_n),
    .scsi_bus_request_n(scsi_bus_request_n),
    .enet_bus_request_n(enet_bus_request_n),
    .scsi_interrupt_out_n(scsi_interrupt_out_n),
    .enet_interrupt_out_n(enet_interrupt_out_n),
    .scsi_dma_need(scsi_dma_need), .enet_dma_need(enet_dma_need),
    .scsi_irq(scsi_irq), .enet_irq(enet_irq), .io_strobe(io_strobe),
    .io_write(io_write), .io_block(io_block), .io_offset(io_offset),
    .io_wdata(io_wdata), .io_be(io_be), .io_rdata(io_rdata));
  host_bridge_model host_bridge_model_inst (.sys_clk(sys_clk),
    .devsel_n(devsel_n), .devsel_oe(devsel_oe), .trdy_n(trdy_n),
    .ad_out(ad_out), .frame_n(frame_n), .irdy_n(irdy_n), .cbe_n(cbe_n),
    .ad_in(ad_in), .scsi_config_select(scsi_config_select),
    .enet_config_select(enet_config_select));
  // register blocks answer with a pattern naming block and offset
  assign io_rdata = {16'hA5C3, 6'h00, io_block, 1'b0, io_offset};
  // capture each register block access
  always @(negedge sys_clk) begin
    if (io_strobe === 1'b1) begin
      seen_blk <= io_block;
      seen_ofs <= io_offset;
      seen_wr <= io_write;
      seen_wdata <= io_wdata;
      seen_be <= io_be;
    end
  end
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp, input string what);
    chk32({31'h0, got}, {31'h0, exp}, what);
  endtask : chk1
  task automatic cyc(input logic [3:0] cmd, input logic [31:0] addr,
      input logic [31:0] wd, input logic [3:0] be_n, input logic [1:0] sel);
    host_bridge_model_inst.bus_cycle(cmd, addr, wd, be_n, sel, claimed,
      rdata);
  endtask : cyc
  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // watchdog cuts a hang short
  initial begin
    #40000;
    errors++;
    final_report();
  end
  // main test sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    cyc(pci_target_pkg::CMD_CFG_READ, 32'h04, 0, 4'h0, 2'b01);
    chk1(claimed, 1'b1, "scsi cfg claim");
    chk32(rdata, {16'h0000, pci_target_pkg::CMD_RESET}, "cmd reset");
    cyc(pci_target_pkg::CMD_CFG_READ, 32'h10, 0, 4'h0, 2'b10);
    chk32(rdata, pci_target_pkg::BAR_RESET, "enet bar reset");
    cyc(pci_target_pkg::CMD_CFG_READ, 32'h10, 0, 4'h0, 2'b00);
    chk1(claimed, 1'b0, "unselected cfg");
    $display("test reset_values done");
    cyc(pci_target_pkg::CMD_CFG_WRITE, 32'h10, 32'hFFFF_FFFF, 4'h0, 2'b01);
    cyc(pci_target_pkg::CMD_CFG_READ, 32'h10, 0, 4'h0, 2'b01);
    chk32(rdata, 32'hFFFF_FF81, "scsi bar mask");
    cyc(pci_target_pkg::CMD_CFG_WRITE, 32'h10, 32'hFFFF_FFFF, 4'h0, 2'b10);
    cyc(pci_target_pkg::CMD_CFG_READ, 32'h10, 0, 4'h0, 2'b10);
    chk32(rdata, 32'hFFFF_FFE1, "enet bar mask");
    cyc(pci_target_pkg::CMD_CFG_WRITE, 32'h3C, 32'h1122_3344, 4'h0, 2'b01);
    cyc(pci_target_pkg::CMD_CFG_WRITE, 32'h3C, 32'hAABB_CCDD, 4'hA, 2'b01);
    cyc(pci_target_pkg::CMD_CFG_READ, 32'h3C, 0, 4'h0, 2'b01);
    chk32(rdata, 32'h11BB_33DD, "byte enables");
    $display("test config_space done");
    cyc(pci_target_pkg::CMD_CFG_WRITE, 32'h10, 32'h0000_1000, 4'h0, 2'b01);
    cyc(pci_target_pkg::CMD_CFG_WRITE, 32'h10, 32'h0000_2000, 4'h0, 2'b10);
    cyc(pci_target_pkg::CMD_IO_READ, 32'h1008, 0, 4'h0, 2'b00);
    chk1(claimed, 1'b0, "io before enable");
    cyc(pci_target_pkg::CMD_CFG_WRITE, 32'h04, 32'h0000_0001, 4'h0, 2'b01);
    cyc(pci_target_pkg::CMD_CFG_WRITE, 32'h04, 32'h0000_0001, 4'h0, 2'b10);
    cyc(pci_target_pkg::CMD_IO_READ, 32'h1008, 0, 4'h0, 2'b00);
    chk1(claimed, 1'b1, "io at new base");
    chk32(rdata, {16'hA5C3, 6'h00, pci_target_pkg::BLK_SCSI_CORE, 8'h08},
      "core read");
    cyc(pci_target_pkg::CMD_IO_READ, 32'h1044, 0, 4'h0, 2'b00);
    chk32(rdata, {16'hA5C3, 6'h00, pci_target_pkg::BLK_SCSI_DMA, 8'h04},
      "dma read");
    cyc(pci_target_pkg::CMD_IO_WRITE, 32'h2010, 32'hCAFE_0123, 4'h5, 2'b00);
    chk32({18'h0, seen_blk, seen_ofs, seen_wr, seen_be},
      {18'h0, pci_target_pkg::BLK_ENET, 7'h10, 1'b1, 4'hA},
      "enet write");
    chk32(seen_wdata, 32'hCAFE_0123, "enet wdata");
    cyc(pci_target_pkg::CMD_IO_READ, 32'h1060, 0, 4'h0, 2'b00);
    chk1(claimed, 1'b0, "past scsi span");
    cyc(4'h6, 32'h1008, 0, 4'h0, 2'b00);
    chk1(claimed, 1'b0, "memory command");
    $display("test io_decode done");
    cyc(pci_target_pkg::CMD_CFG_WRITE, 32'h04, 32'h0000_0005, 4'h0, 2'b01);
    scsi_dma_need = 1'b1;
    enet_dma_need = 1'b1;
    scsi_bus_grant_n = 1'b0;
    scsi_irq = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk1(scsi_bus_request_n, 1'b0, "scsi request");
    chk1(enet_bus_request_n, 1'b1, "enet request");
    chk1(scsi_interrupt_out_n, 1'b0, "scsi interrupt");
    chk1(enet_interrupt_out_n, 1'b1, "enet interrupt");
    cyc(pci_target_pkg::CMD_IO_READ, 32'h1008, 0, 4'h0, 2'b00);
    chk1(claimed, 1'b0, "io while master");
    cyc(pci_target_pkg::CMD_IO_READ, 32'h2004, 0, 4'h0, 2'b00);
    chk1(claimed, 1'b0, "other function io while master");
    scsi_dma_need = 1'b0;
    scsi_bus_grant_n = 1'b1;
    scsi_irq = 1'b0;
    enet_irq = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk1(enet_interrupt_out_n, 1'b0, "enet interrupt on");
    chk1(scsi_interrupt_out_n, 1'b1, "scsi interrupt off");
    cyc(pci_target_pkg::CMD_IO_READ, 32'h2004, 0, 4'h0, 2'b00);
    chk1(claimed, 1'b1, "io after master");
    chk32(rdata, {16'hA5C3, 6'h00, pci_target_pkg::BLK_ENET, 8'h04},
      "enet read");
    $display("test functions done");
    final_report();
  end
endmodule : pci_target_config_decode_tb
bind pci_target_config_decode pci_target_config_decode_sva sva_inst (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .frame_n(frame_n), .cbe_n(cbe_n),
  .scsi_config_select(scsi_config_select),
  .enet_config_select(enet_config_select), .devsel_oe(devsel_oe),
  .trdy_n(trdy_n), .trdy_oe(trdy_oe), .ad_oe(ad_oe), .io_strobe(io_strobe),
  .scsi_irq(scsi_irq), .enet_irq(enet_irq),
  .scsi_interrupt_out_n(scsi_interrupt_out_n),
  .enet_interrupt_out_n(enet_interrupt_out_n));

// file: pci_target_pkg.sv
package pci_target_pkg;
  // pci bus commands
  localparam logic [3:0] CMD_IO_READ = 4'h2;
  localparam logic [3:0] CMD_IO_WRITE = 4'h3;
  localparam logic [3:0] CMD_CFG_READ = 4'hA;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hB;
  // configuration space byte offsets
  localparam logic [7:0] CFG_ID_OFS = 8'h00;
  localparam logic [7:0] CFG_CMD_OFS = 8'h04;
  localparam logic [7:0] CFG_CLASS_OFS = 8'h08;
  localparam logic [7:0] CFG_BAR_OFS = 8'h10;
  localparam logic [7:0] CFG_MAIL_OFS = 8'h3C;
  // command register fields and writable bits
  localparam int IO_EN_BIT = 0;
  localparam int MASTER_EN_BIT = 2;
  localparam logic [15:0] CMD_WR_MASK = 16'h0005;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [31:0] BAR_RESET = 32'h0000_0001;
  localparam logic [31:0] MAIL_RESET = 32'h0000_0000;
  localparam logic [31:0] BAR_IO_FLAG = 32'h0000_0001;
  // window alignment in address bits
  localparam int SCSI_ALIGN_BITS = 7;
  localparam int ENET_ALIGN_BITS = 5;
  localparam logic [6:0] SCSI_CORE_LAST = 7'h3F;
  localparam logic [6:0] SCSI_DMA_FIRST = 7'h40;
  localparam logic [6:0] SCSI_DMA_LAST = 7'h5F;
  // register block selected by an i/o access
  typedef enum logic [1:0] {
    BLK_SCSI_CORE = 2'b00,
    BLK_SCSI_DMA = 2'b01,
    BLK_ENET = 2'b10
  } io_block_e;
endpackage : pci_target_pkg
